//--- rtl/psf_pkg.sv
/*
 * Shared constants for the sampled PID servo filter: register offsets,
 * reset values, widths, timing counts and the sequencer state type.
 * Assumes a single 100 MHz clock and a 32-bit AHB-Lite register bus.
 */
package psf_pkg;
    // Clock and timing.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned US_NS         = 1000;
    localparam int unsigned CYC_PER_US    = US_NS / CLK_PERIOD_NS;
    localparam int unsigned MIN_PERIOD_US = 200;

    // Data widths.
    localparam int unsigned POS_W  = 32;
    localparam int unsigned DRV_W  = 12;
    localparam int unsigned GAIN_W = 16;
    localparam int unsigned ACC_W  = 15;
    localparam int unsigned PER_W  = 16;
    localparam int unsigned OUT_SHIFT = 8;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_KP     = 8'h08;
    localparam logic [7:0] OFS_KI     = 8'h0C;
    localparam logic [7:0] OFS_KD     = 8'h10;
    localparam logic [7:0] OFS_TARGET = 8'h14;
    localparam logic [7:0] OFS_POS    = 8'h18;
    localparam logic [7:0] OFS_DRIVE  = 8'h1C;
    localparam logic [7:0] OFS_ILIMIT = 8'h20;
    localparam logic [7:0] OFS_ACCEL  = 8'h24;
    localparam logic [7:0] OFS_VEL    = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;

    // Field positions.
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned STAT_DIR_BIT  = 0;
    localparam int unsigned STAT_BUSY_BIT = 1;

    // Reset values and drive saturation limits.
    localparam logic [PER_W-1:0]  PERIOD_RST = 16'h03E8;
    localparam logic [GAIN_W-1:0] KP_RST     = 16'h0000;
    localparam logic [GAIN_W-1:0] KI_RST     = 16'h0000;
    localparam logic [GAIN_W-1:0] KD_RST     = 16'h0000;
    localparam logic [DRV_W-1:0]  ILIM_RST   = 12'h7FF;
    localparam logic [ACC_W-1:0]  ACCEL_RST  = 15'h0000;
    localparam logic [DRV_W-1:0]  DRV_POS_MAX = 12'h7FF;
    localparam logic [DRV_W-1:0]  DRV_NEG_MAX = 12'h800;

    typedef enum {ST_IDLE, ST_CALC, ST_MULT, ST_SUM} psf_state_e;
endpackage

//--- rtl/psf_quad_dec.sv
/*
 * Quadrature decoder: turns two encoder channels into a signed up/down
 * position count, one count per channel edge.
 * Assumes enc_a and enc_b arrive asynchronously from pins.
 */
`timescale 1ns/10ps
`default_nettype none
module psf_quad_dec
    import psf_pkg::*;
#(
    parameter int unsigned CNT_W = POS_W
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              enc_a,
    input  wire logic              enc_b,
    output logic signed [CNT_W-1:0] count
);
    logic a_s1, a_s2, a_prev;
    logic b_s1, b_s2, b_prev;
    logic edge_a, edge_b;
    logic [2:0] arm_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_s1   <= 1'b0;
            a_s2   <= 1'b0;
            a_prev <= 1'b0;
            b_s1   <= 1'b0;
            b_s2   <= 1'b0;
            b_prev <= 1'b0;
            arm_reg <= 3'h0;
        end else begin
            arm_reg <= {arm_reg[1:0], 1'b1};
            a_s1   <= enc_a;
            a_s2   <= a_s1;
            a_prev <= a_s2;
            b_s1   <= enc_b;
            b_s2   <= b_s1;
            b_prev <= b_s2;
        end
    end

    assign edge_a = a_s2 ^ a_prev;
    assign edge_b = b_s2 ^ b_prev;

    // One edge per clock is counted; both channels moving at once is a lost step and is dropped.
    // Edges wait until the sync and previous flops hold real pin levels, so a pin high at reset
    // is not taken for a step.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (arm_reg[2] && (edge_a ^ edge_b)) begin
            if (a_prev ^ b_s2) begin
                count <= count + CNT_W'(1);
            end else begin
                count <= count - CNT_W'(1);
            end
        end
    end

    count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(count) |-> (count - $past(count) == CNT_W'(1))
                         || ($past(count) - count == CNT_W'(1)))
        else $error("Position count moved by more than one step.");
endmodule
`default_nettype wire

//--- rtl/psf_servo_top.sv
/*
 * Sampled PID servo filter with an AHB-Lite register slave, a quadrature
 * position counter, a programmable sample timer and a saturating 12-bit
 * drive output with direction bit and current limit output.
 * Assumes one 100 MHz clock, a single AHB-Lite master and word accesses.
 */
`timescale 1ns/10ps
`default_nettype none
module psf_servo_top
    import psf_pkg::*;
#(
    parameter int unsigned US_CYCLES  = CYC_PER_US,
    parameter int unsigned MIN_PER_US = MIN_PERIOD_US
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire logic                enc_a,
    input  wire logic                enc_b,
    output logic [psf_pkg::DRV_W-1:0] drive_out,
    output logic                     dir_out,
    output logic [psf_pkg::DRV_W-1:0] ilimit_out
);
    localparam int MIN_GAP = MIN_PER_US * US_CYCLES - 1;

    logic                     ctrl_en_reg;
    logic [PER_W-1:0]         servo_sample_period_reg;
    logic signed [GAIN_W-1:0] kp_reg, ki_reg, kd_reg;
    logic signed [POS_W-1:0]  target_reg;
    logic [ACC_W-1:0]         accel_reg;
    logic [DRV_W-1:0]         ilimit_reg;
    logic                     wr_pend_reg;
    logic [7:0]               addr_reg;
    logic [7:0]               unused_size;
    logic [31:0]              rd_next;

    logic signed [POS_W-1:0]  pos_count, pos_snap, pos_prev;
    logic signed [POS_W-1:0]  vel_reg;
    logic signed [POS_W:0]    err_reg, err_prev;
    logic signed [POS_W+1:0]  diff_now, diff_prev, d_avg;
    logic signed [POS_W+2:0]  diff_sum;
    logic signed [POS_W-1:0]  integ_reg;
    logic signed [POS_W+1:0]  integ_sum;
    logic signed [51:0]       p_term, i_term, d_term, total, scaled;
    logic [DRV_W-1:0]         drive_reg, drive_next;
    logic                     dir_reg;
    psf_state_e               state;

    logic [6:0]               us_cnt;
    logic                     us_tick;
    logic [PER_W-1:0]         per_cnt, eff_period;
    logic                     sample_tick;
    logic [31:0]              gap_cnt;
    logic                     gap_seen;

    assign unused_size = {5'h00, hsize};

    psf_quad_dec #(
        .CNT_W (POS_W)
    ) u_quad (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enc_a   (enc_a),
        .enc_b   (enc_b),
        .count   (pos_count)
    );

    // Bus slave: zero wait states, always OKAY, unmapped reads return zero.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            addr_reg    <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_en_reg             <= 1'b0;
            servo_sample_period_reg <= PERIOD_RST;
            kp_reg                  <= KP_RST;
            ki_reg                  <= KI_RST;
            kd_reg                  <= KD_RST;
            target_reg              <= '0;
            ilimit_reg              <= ILIM_RST;
            accel_reg               <= ACCEL_RST;
        end else if (wr_pend_reg) begin
            case (addr_reg)
                OFS_CTRL:   ctrl_en_reg <= hwdata[CTRL_EN_BIT];
                OFS_PERIOD: servo_sample_period_reg <= hwdata[PER_W-1:0];
                OFS_KP:     kp_reg <= hwdata[GAIN_W-1:0];
                OFS_KI:     ki_reg <= hwdata[GAIN_W-1:0];
                OFS_KD:     kd_reg <= hwdata[GAIN_W-1:0];
                OFS_TARGET: target_reg <= hwdata;
                OFS_ILIMIT: ilimit_reg <= hwdata[DRV_W-1:0];
                OFS_ACCEL:  accel_reg <= hwdata[ACC_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data is chosen in the address phase and stands in a flop through the data phase.
    // A read overlapping the data phase of a write to the same register returns the old value.
    always_comb begin
        rd_next = 32'h0000_0000;
        case (haddr[7:0])
            OFS_CTRL:   rd_next[CTRL_EN_BIT] = ctrl_en_reg;
            OFS_PERIOD: rd_next[PER_W-1:0] = servo_sample_period_reg;
            OFS_KP:     rd_next[GAIN_W-1:0] = kp_reg;
            OFS_KI:     rd_next[GAIN_W-1:0] = ki_reg;
            OFS_KD:     rd_next[GAIN_W-1:0] = kd_reg;
            OFS_TARGET: rd_next = target_reg;
            OFS_POS:    rd_next = pos_count;
            OFS_DRIVE:  rd_next[DRV_W-1:0] = drive_reg;
            OFS_ILIMIT: rd_next[DRV_W-1:0] = ilimit_reg;
            OFS_ACCEL:  rd_next[ACC_W-1:0] = accel_reg;
            OFS_VEL:    rd_next = vel_reg;
            OFS_STATUS: begin
                rd_next[STAT_DIR_BIT]  = dir_reg;
                rd_next[STAT_BUSY_BIT] = (state != ST_IDLE);
            end
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= rd_next;
        end
    end

    // Sample timer: a microsecond enable, then a count of microseconds per sample.
    assign eff_period = (servo_sample_period_reg < PER_W'(MIN_PER_US))
                      ? PER_W'(MIN_PER_US) : servo_sample_period_reg;
    assign us_tick     = (us_cnt == 7'(US_CYCLES - 1));
    assign sample_tick = us_tick && (per_cnt >= eff_period - PER_W'(1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            us_cnt  <= 7'h00;
            per_cnt <= '0;
        end else begin
            us_cnt <= us_tick ? 7'h00 : us_cnt + 7'h01;
            if (sample_tick) begin
                per_cnt <= '0;
            end else if (us_tick) begin
                per_cnt <= per_cnt + PER_W'(1);
            end
        end
    end

    // Filter sequencer: snapshot, error and velocity, integrate and differentiate, sum.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: state <= sample_tick ? ST_CALC : ST_IDLE;
                ST_CALC: state <= ST_MULT;
                ST_MULT: state <= ST_SUM;
                ST_SUM:  state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign diff_now  = (POS_W+2)'(err_reg) - (POS_W+2)'(err_prev);
    assign diff_sum  = (POS_W+3)'(diff_now) + (POS_W+3)'(diff_prev);
    assign integ_sum = (POS_W+2)'(integ_reg) + (POS_W+2)'(err_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_snap  <= '0;
            pos_prev  <= '0;
            vel_reg   <= '0;
            err_reg   <= '0;
            err_prev  <= '0;
            diff_prev <= '0;
            d_avg     <= '0;
            integ_reg <= '0;
        end else begin
            if (state == ST_IDLE && sample_tick) begin
                pos_snap <= pos_count;
            end
            if (state == ST_CALC) begin
                err_reg  <= (POS_W+1)'(target_reg) - (POS_W+1)'(pos_snap);
                vel_reg  <= pos_snap - pos_prev;
                pos_prev <= pos_snap;
            end
            if (state == ST_MULT) begin
                d_avg     <= diff_sum[POS_W+2:1];
                diff_prev <= diff_now;
                err_prev  <= err_reg;
                if (!ctrl_en_reg || ki_reg == '0) begin
                    integ_reg <= '0;
                end else if (integ_sum > $signed((POS_W+2)'({1'b0, {(POS_W-1){1'b1}}}))) begin
                    integ_reg <= {1'b0, {(POS_W-1){1'b1}}};
                end else if (integ_sum < -$signed((POS_W+2)'({1'b1, {(POS_W-1){1'b0}}}))) begin
                    integ_reg <= {1'b1, {(POS_W-1){1'b0}}};
                end else begin
                    integ_reg <= integ_sum[POS_W-1:0];
                end
            end
        end
    end

    // Three parallel paths, scaled down and clamped to the 12-bit drive range.
    assign p_term = 52'(kp_reg) * 52'(err_reg);
    assign i_term = 52'(ki_reg) * 52'(integ_reg);
    assign d_term = 52'(kd_reg) * 52'(d_avg);
    assign total  = p_term + i_term + d_term;
    assign scaled = total >>> OUT_SHIFT;

    always_comb begin
        if (&scaled[51:DRV_W-1] || ~|scaled[51:DRV_W-1]) begin
            drive_next = scaled[DRV_W-1:0];
        end else if (scaled[51]) begin
            drive_next = DRV_NEG_MAX;
        end else begin
            drive_next = DRV_POS_MAX;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_reg <= '0;
            dir_reg   <= 1'b0;
        end else if (!ctrl_en_reg) begin
            drive_reg <= '0;
            dir_reg   <= 1'b0;
        end else if (state == ST_SUM) begin
            drive_reg <= drive_next;
            dir_reg   <= drive_next[DRV_W-1];
        end
    end

    assign drive_out  = drive_reg;
    assign dir_out    = dir_reg;
    assign ilimit_out = ilimit_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_cnt  <= 32'h0000_0000;
            gap_seen <= 1'b0;
        end else begin
            gap_cnt  <= sample_tick ? 32'h0000_0000 : gap_cnt + 32'h0000_0001;
            gap_seen <= gap_seen | sample_tick;
        end
    end

    period_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sample_tick && gap_seen |-> gap_cnt >= 32'(MIN_GAP))
        else $error("Sample ticks closer than the minimum period.");
    update_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sample_tick && state == ST_IDLE |=> state == ST_CALC ##1 state == ST_MULT
                                        ##1 state == ST_SUM ##1 state == ST_IDLE)
        else $error("Filter update did not finish in four cycles.");
    ki_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state == ST_MULT && ki_reg == '0 |=> integ_reg == '0)
        else $error("Integral path active with zero gain.");
    integ_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state == ST_MULT && ctrl_en_reg && ki_reg != '0 && integ_sum[POS_W+1:POS_W-1] == 3'h0
        |=> integ_reg == $past(integ_reg) + POS_W'($past(err_reg)))
        else $error("Integrator did not add the present error.");
    deriv_avg_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state == ST_MULT |=> d_avg == (POS_W+2)'(((POS_W+3)'($past(diff_now))
                                     + (POS_W+3)'($past(diff_prev))) >>> 1))
        else $error("Derivative average wrong.");
    vel_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state == ST_CALC |=> vel_reg == $past(pos_snap) - $past(pos_prev))
        else $error("Velocity is not the count difference per sample.");
    drive_sat_a: assert property (@(posedge hclk) disable iff (!hresetn)
        state == ST_SUM && ctrl_en_reg && !scaled[51] && |scaled[51:DRV_W-1]
        |=> drive_out == DRV_POS_MAX)
        else $error("Positive overflow did not saturate.");
    dir_sign_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(drive_out) |-> dir_out == drive_out[DRV_W-1])
        else $error("Direction bit disagrees with drive sign.");
    ilimit_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_reg && addr_reg == OFS_ILIMIT |=> ilimit_out == $past(hwdata[DRV_W-1:0]))
        else $error("Current limit write not applied.");
endmodule
`default_nettype wire

//--- sim/psf_enc_model.sv
/*
 * Behavioural two-channel quadrature encoder that drives the servo block.
 * Assumes the caller sits just after a rising edge of hclk when it moves.
 */
`timescale 1ns/10ps
`default_nettype none
module psf_enc_model (
    input  wire logic hclk,
    output logic      enc_a,
    output logic      enc_b
);
    logic [1:0] phase = 2'b00;

    // Gray order 00, 01, 11, 10 with channel B leading A counts up.
    assign enc_a = phase[1];
    assign enc_b = phase[1] ^ phase[0];

    // Six clocks per edge, far faster than the top documented edge rate.
    task automatic move(input int n);
        int i;
        for (i = 0; i < ((n < 0) ? -n : n); i++) begin
            phase <= (n < 0) ? phase - 2'd1 : phase + 2'd1;
            repeat (6) @(posedge hclk);
        end
    endtask
endmodule
`default_nettype wire

//--- sim/sampled_pid_servo_filter_tb_top.sv
/*
 * Self-checking bench for the servo filter: register rows, encoder count,
 * proportional, derivative and integral paths, saturation and sample gap.
 * Assumes the filter top, its package and the encoder model are compiled.
 */
`timescale 1ns/10ps
`default_nettype none
module sampled_pid_servo_filter_tb_top;
    import psf_pkg::*;
    localparam int unsigned US  = 2;
    localparam int unsigned GAP = 2 * MIN_PERIOD_US * US;
    localparam logic [7:0]  R_ADDR [6] = '{OFS_ILIMIT, OFS_ACCEL, OFS_TARGET, OFS_POS, 8'h40,
                                           OFS_PERIOD};
    localparam logic [31:0] R_WD [6]   = '{32'h00000ABC, 32'h00007FFF, 32'h80000001,
                                           32'h00001234, 32'hFFFFFFFF, 32'h000000C8};
    localparam logic [31:0] R_EX [6]   = '{32'h00000ABC, 32'h00007FFF, 32'h80000001,
                                           32'h00000000, 32'h00000000, 32'h000000C8};

    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic             hwrite;
    logic             hreadyout;
    logic             hresp;
    logic             dir_out;
    logic             enc_a;
    logic             enc_b;
    logic             hr_q;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [31:0]      haddr;
    logic [31:0]      hwdata;
    logic [31:0]      hrdata;
    logic [31:0]      rd_q;
    logic [31:0]      rv;
    logic [DRV_W-1:0] drive_out;
    logic [DRV_W-1:0] ilimit_out;
    int               n_errors   = 0;
    int               n_compared = 0;
    int               i;
    time              t0;

    psf_servo_top #(.US_CYCLES(US), .MIN_PER_US(MIN_PERIOD_US)) u_psf_servo_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .enc_a(enc_a),
        .enc_b(enc_b), .drive_out(drive_out), .dir_out(dir_out), .ilimit_out(ilimit_out)
    );
    psf_enc_model u_psf_enc_model (.hclk(hclk), .enc_a(enc_a), .enc_b(enc_b));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Bus answers are captured at the edge so that reads never race the slave.
    always @(posedge hclk) begin
        rd_q <= hrdata;
        hr_q <= hreadyout;
    end

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic hang();
        n_errors++;
        $display("mismatch wait expected done seen timeout");
        finish_test();
    endtask

    task automatic tick();
        @(posedge hclk);
        #1;
    endtask

    task automatic wait_ready();
        int k;
        for (k = 0; k < 20; k++) begin
            tick();
            if (hr_q === 1'b1) return;
        end
        hang();
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rv = rd_q;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(what, rv, e);
    endtask

    task automatic wait_drv(input logic [DRV_W-1:0] v, input bit eq);
        int k;
        for (k = 0; k < 3000; k++) begin
            tick();
            if ((drive_out === v) == eq) return;
        end
        hang();
    endtask

    task automatic chk_drv(input logic [DRV_W-1:0] e);
        chk("drive_out", {20'h00000, drive_out}, {20'h00000, e});
        chk("dir_out", {31'h00000000, dir_out}, {31'h00000000, e[DRV_W-1]});
    endtask

    initial begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h00000000;
        htrans  = 2'b00;
        hwrite  = 1'b0;
        hsize   = 3'b010;
        hwdata  = 32'h00000000;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        tick();
        chk("ilimit_out", {20'h00000, ilimit_out}, 32'h000007FF);
        chk_drv(12'h000);
        chk("hresp", {31'h00000000, hresp}, 32'h00000000);
        rchk("period", OFS_PERIOD, {16'h0000, PERIOD_RST});
        $display("test reset done");

        for (i = 0; i < 6; i++) begin
            wr(R_ADDR[i], R_WD[i]);
            rchk("register row", R_ADDR[i], R_EX[i]);
        end
        chk("ilimit_out", {20'h00000, ilimit_out}, 32'h00000ABC);
        $display("test register rows done");

        u_psf_enc_model.move(10);
        rchk("position", OFS_POS, 32'h0000000A);
        u_psf_enc_model.move(-3);
        rchk("position", OFS_POS, 32'h00000007);
        $display("test encoder done");

        // Proportional only: error 100 at gain 256 gives 100 after the shift.
        wr(OFS_PERIOD, 32'h00000064);
        wr(OFS_KP, 32'h00000100);
        wr(OFS_TARGET, 32'h0000006B);
        wr(OFS_CTRL, 32'h00000001);
        wait_drv(12'h064, 1'b1);
        chk_drv(12'h064);
        repeat (GAP / 2 + 20) @(posedge hclk);
        chk_drv(12'h064);
        wr(OFS_TARGET, 32'h000186A7);
        wait_drv(12'h7FF, 1'b1);
        chk_drv(12'h7FF);
        wr(OFS_TARGET, 32'hFFFE7967);
        wait_drv(12'h800, 1'b1);
        chk_drv(12'h800);
        rchk("drive reg", OFS_DRIVE, 32'h00000800);
        rchk("status", OFS_STATUS, 32'h00000001);
        $display("test proportional done");

        // Derivative only: a 4 count step gives a drive of -4 twice, that is two sample periods.
        wr(OFS_KP, 32'h00000000);
        wr(OFS_TARGET, 32'h00000007);
        wait_drv(12'h000, 1'b1);
        wr(OFS_KD, 32'h00000200);
        wait_drv(12'h000, 1'b0);
        wait_drv(12'h000, 1'b1);
        u_psf_enc_model.move(4);
        wait_drv(12'hFFC, 1'b1);
        t0 = $time;
        chk_drv(12'hFFC);
        rchk("velocity", OFS_VEL, 32'h00000004);
        wait_drv(12'hFFC, 1'b0);
        chk("sample gap", 32'(($time - t0) / 10), 32'(GAP));
        chk_drv(12'h000);
        $display("test derivative done");

        // Integral plus proportional: error 16, drive 16 plus one per sample.
        wr(OFS_KD, 32'h00000000);
        wr(OFS_CTRL, 32'h00000000);
        wr(OFS_KP, 32'h00000100);
        wr(OFS_KI, 32'h00000010);
        wr(OFS_TARGET, 32'h0000001B);
        wr(OFS_CTRL, 32'h00000001);
        wait_drv(12'h000, 1'b0);
        chk_drv(12'h011);
        wait_drv(12'h011, 1'b0);
        chk_drv(12'h012);
        // Integral gain of zero clears the sum; turning it back on starts from the present error.
        wr(OFS_KI, 32'h00000000);
        wait_drv(12'h012, 1'b0);
        chk_drv(12'h010);
        wr(OFS_KI, 32'h00000010);
        wait_drv(12'h010, 1'b0);
        chk_drv(12'h011);
        $display("test integral done");

        // Reset in mid-run with the loop enabled and the encoder resting off zero.
        hresetn <= 1'b0;
        tick();
        chk_drv(12'h000);
        chk("ilimit_out", {20'h00000, ilimit_out}, 32'h000007FF);
        hresetn <= 1'b1;
        tick();
        rchk("period", OFS_PERIOD, {16'h0000, PERIOD_RST});
        rchk("position", OFS_POS, 32'h00000000);
        u_psf_enc_model.move(1);
        rchk("position", OFS_POS, 32'h00000001);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule
`default_nettype wire
